/* src/hub_cfg_pkg.sv */
/*
 * Constants, types and register map for the hub string and port power
 * register group. Assumes an 8-bit address, 8-bit data configuration port.
 */
// Notes on behaviour
// - Product string bytes live at 0x54 to 0x91, UTF-16LE, read by the USB side.
// - Serial number bytes live at 0x92 to 0xCF, UTF-16LE, read by the USB side.
// - Charge enable bits 3..1 enable charging on ports 3..1; others reserved.
// - Charge enable bit one means enabled; zero, the reset value, disabled.
// - Port power status bits 3..1 are read only; writes change nothing.
// - A status bit is one when the USB host has powered that port and no over-current cut applies to it.
// - Status is zero without host power, or with charging and over-current set.
// - Power state combines host request, over-current flags and charging logic.
// - A register-controlled over-current flag clears that port's status bit.
package hub_cfg_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned NUM_PORTS = 3;

	localparam logic [ADDR_W-1:0] PRODUCT_STRING_FIRST = 8'h54;
	localparam logic [ADDR_W-1:0] PRODUCT_STRING_LAST  = 8'h91;
	localparam logic [ADDR_W-1:0] SERIAL_STRING_FIRST  = 8'h92;
	localparam logic [ADDR_W-1:0] SERIAL_STRING_LAST   = 8'hCF;
	localparam logic [ADDR_W-1:0] BATTERY_CHARGE_OFS   = 8'hD0;
	localparam logic [ADDR_W-1:0] PORT_POWER_OFS       = 8'hE5;

	localparam int unsigned STRING_BYTES = 62;
	localparam int unsigned STR_IDX_W = 6;

	localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
	localparam logic [DATA_W-1:0] BATTERY_CHARGE_RESET = 8'h00;
	localparam logic [DATA_W-1:0] PORT_BITS_MASK = 8'h0E;
	localparam int unsigned PORT_LSB = 1;

	typedef enum logic {
		STR_PRODUCT,
		STR_SERIAL
	} string_sel_e;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} cfg_req_s;

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] rdata;
	} cfg_rsp_s;

	typedef struct packed {
		logic                 rd;
		string_sel_e          sel;
		logic [STR_IDX_W-1:0] index;
	} desc_req_s;

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] data;
	} desc_rsp_s;

endpackage

/* src/hub_string_and_port_power_regs.sv */
/*
 * Register group holding the product and serial string bytes, the
 * per-port battery charge enable and the read-only port power status.
 * Assumes the serial configuration port decoder and the USB descriptor
 * engine run on clk_sys and present single-cycle request strobes.
 */
`timescale 1ns/1ps
`default_nettype none

module hub_string_and_port_power_regs
	import hub_cfg_pkg::*;
#(
	parameter int unsigned STR_BYTES = STRING_BYTES
) (
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	input  wire cfg_req_s             cfg_req,
	output var  cfg_rsp_s             cfg_rsp,
	input  wire desc_req_s            desc_req,
	output var  desc_rsp_s            desc_rsp,
	input  wire logic [NUM_PORTS-1:0] host_port_power_req,
	input  wire logic [NUM_PORTS-1:0] overcurrent_flag_bits,
	input  wire logic [NUM_PORTS-1:0] overcurrent_reg_control,
	output logic      [NUM_PORTS-1:0] battery_charge_enable,
	output logic      [NUM_PORTS-1:0] port_power_status
);

	logic [DATA_W-1:0]    product_string_array_reg [STR_BYTES];
	logic [DATA_W-1:0]    product_string_array_next[STR_BYTES];
	logic [DATA_W-1:0]    serial_number_array_reg  [STR_BYTES];
	logic [DATA_W-1:0]    serial_number_array_next [STR_BYTES];
	logic [NUM_PORTS-1:0] charge_en_reg;
	logic [NUM_PORTS-1:0] charge_en_next;
	logic [NUM_PORTS-1:0] power_reg;
	logic [NUM_PORTS-1:0] power_next;
	cfg_rsp_s             cfg_rsp_reg;
	cfg_rsp_s             cfg_rsp_next;
	desc_rsp_s            desc_rsp_reg;
	desc_rsp_s            desc_rsp_next;
	logic [DATA_W-1:0]    port_field;
	logic                 oc_cut;

	function automatic logic in_window(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] first,
		input logic [ADDR_W-1:0] last
	);
		in_window = (a >= first) && (a <= last);
	endfunction

	function automatic logic [STR_IDX_W-1:0] byte_index(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] first
	);
		logic [ADDR_W-1:0] diff;
		diff = a - first;
		byte_index = diff[STR_IDX_W-1:0];
	endfunction

	// Byte arrays: the configuring party orders UTF-16LE bytes itself, so
	// each address is stored verbatim with no byte swapping here.
	always_comb begin
		product_string_array_next = product_string_array_reg;
		serial_number_array_next  = serial_number_array_reg;
		if (cfg_req.wr && in_window(cfg_req.addr, PRODUCT_STRING_FIRST, PRODUCT_STRING_LAST)) begin
			product_string_array_next[byte_index(cfg_req.addr, PRODUCT_STRING_FIRST)] =
				cfg_req.wdata;
		end
		if (cfg_req.wr && in_window(cfg_req.addr, SERIAL_STRING_FIRST, SERIAL_STRING_LAST)) begin
			serial_number_array_next[byte_index(cfg_req.addr, SERIAL_STRING_FIRST)] =
				cfg_req.wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < STR_BYTES; i++) begin
				product_string_array_reg[i] <= BYTE_RESET;
				serial_number_array_reg[i]  <= BYTE_RESET;
			end
		end else begin
			product_string_array_reg <= product_string_array_next;
			serial_number_array_reg  <= serial_number_array_next;
		end
	end

	// Charge enable: only the port bits are stored, reserved bits drop out
	always_comb begin
		charge_en_next = charge_en_reg;
		if (cfg_req.wr && cfg_req.addr == BATTERY_CHARGE_OFS) begin
			charge_en_next = cfg_req.wdata[PORT_LSB +: NUM_PORTS];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			charge_en_reg <= BATTERY_CHARGE_RESET[PORT_LSB +: NUM_PORTS];
		end else begin
			charge_en_reg <= charge_en_next;
		end
	end

	// Port power: host request gated by over-current. No write path exists.
	always_comb begin
		power_next = '0;
		oc_cut     = 1'b0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			oc_cut = overcurrent_flag_bits[p] && (charge_en_reg[p] || overcurrent_reg_control[p]);
			power_next[p] = host_port_power_req[p] && !oc_cut;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			power_reg <= '0;
		end else begin
			power_reg <= power_next;
		end
	end

	// Configuration read answer, one cycle after the strobe
	always_comb begin
		port_field          = '0;
		cfg_rsp_next.valid  = cfg_req.rd;
		cfg_rsp_next.rdata  = '0;
		if (cfg_req.rd) begin
			if (in_window(cfg_req.addr, PRODUCT_STRING_FIRST, PRODUCT_STRING_LAST)) begin
				cfg_rsp_next.rdata =
					product_string_array_reg[byte_index(cfg_req.addr, PRODUCT_STRING_FIRST)];
			end else if (in_window(cfg_req.addr, SERIAL_STRING_FIRST, SERIAL_STRING_LAST)) begin
				cfg_rsp_next.rdata =
					serial_number_array_reg[byte_index(cfg_req.addr, SERIAL_STRING_FIRST)];
			end else if (cfg_req.addr == BATTERY_CHARGE_OFS) begin
				port_field[PORT_LSB +: NUM_PORTS] = charge_en_reg;
				cfg_rsp_next.rdata = port_field & PORT_BITS_MASK;
			end else if (cfg_req.addr == PORT_POWER_OFS) begin
				port_field[PORT_LSB +: NUM_PORTS] = power_reg;
				cfg_rsp_next.rdata = port_field & PORT_BITS_MASK;
			end
		end
	end

	// Descriptor engine read port; index beyond the array returns zero
	always_comb begin
		desc_rsp_next.valid = desc_req.rd;
		desc_rsp_next.data  = '0;
		if (desc_req.rd && desc_req.index < STR_IDX_W'(STR_BYTES)) begin
			unique case (desc_req.sel)
				STR_PRODUCT: desc_rsp_next.data = product_string_array_reg[desc_req.index];
				STR_SERIAL:  desc_rsp_next.data = serial_number_array_reg[desc_req.index];
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cfg_rsp_reg  <= '0;
			desc_rsp_reg <= '0;
		end else begin
			cfg_rsp_reg  <= cfg_rsp_next;
			desc_rsp_reg <= desc_rsp_next;
		end
	end

	assign cfg_rsp               = cfg_rsp_reg;
	assign desc_rsp              = desc_rsp_reg;
	assign battery_charge_enable = charge_en_reg;
	assign port_power_status     = power_reg;

endmodule

`default_nettype wire

/* dv/hub_regs_chk.sv */
/* Assertions on the string and port power register block.
   Sees only the block's ports; bound in at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module hub_regs_chk
	import hub_cfg_pkg::*;
#(
	parameter int unsigned STR_BYTES = STRING_BYTES
) (
	input wire logic           clk_sys,
	input wire logic           resetn,
	input wire cfg_req_s       cfg_req,
	input wire cfg_rsp_s       cfg_rsp,
	input wire desc_req_s      desc_req,
	input wire desc_rsp_s      desc_rsp,
	input wire logic [NUM_PORTS-1:0] host_port_power_req,
	input wire logic [NUM_PORTS-1:0] overcurrent_flag_bits,
	input wire logic [NUM_PORTS-1:0] overcurrent_reg_control,
	input wire logic [NUM_PORTS-1:0] battery_charge_enable,
	input wire logic [NUM_PORTS-1:0] port_power_status
);
	logic [NUM_PORTS-1:0] pwr_want;
	logic                 bc_wr;
	assign pwr_want = host_port_power_req & ~(overcurrent_flag_bits
		& (battery_charge_enable | overcurrent_reg_control));
	assign bc_wr = cfg_req.wr && cfg_req.addr == BATTERY_CHARGE_OFS;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	AST_RSP: assert property (cfg_req.rd |=> cfg_rsp.valid)
		else $error("read got no answer");
	AST_IDLE: assert property (!cfg_req.rd |=> !cfg_rsp.valid && !cfg_rsp.rdata)
		else $error("answer without read");
	AST_DESC: assert property (desc_req.rd |=> desc_rsp.valid)
		else $error("descriptor read got no answer");
	AST_DIDX: assert property (desc_req.rd && desc_req.index >= STR_BYTES |=> !desc_rsp.data)
		else $error("index past string end not zero");
	AST_BCWR: assert property (bc_wr |=> battery_charge_enable == $past(cfg_req.wdata[3:1]))
		else $error("charge enable write lost");
	AST_BCHOLD: assert property (!bc_wr |=> $stable(battery_charge_enable))
		else $error("charge enable moved");
	AST_BCRD: assert property (cfg_req.rd && cfg_req.addr == BATTERY_CHARGE_OFS |=>
		cfg_rsp.rdata == {4'h0, $past(battery_charge_enable), 1'b0}) else $error("bad enable read");
	AST_PRRD: assert property (cfg_req.rd && cfg_req.addr == PORT_POWER_OFS |=>
		cfg_rsp.rdata == {4'h0, $past(port_power_status), 1'b0}) else $error("bad status read");
	AST_PWR: assert property ($past(resetn) |-> port_power_status == $past(pwr_want))
		else $error("port power status wrong");
	cover property (bc_wr);
	cover property (desc_req.rd && desc_req.index >= STR_BYTES);
	cover property (|(overcurrent_flag_bits & host_port_power_req & battery_charge_enable));
endmodule
bind hub_string_and_port_power_regs hub_regs_chk #(.STR_BYTES(STR_BYTES)) u_chk (.clk_sys,
	.resetn, .cfg_req, .cfg_rsp, .desc_req, .desc_rsp, .host_port_power_req,
	.overcurrent_flag_bits, .overcurrent_reg_control, .battery_charge_enable, .port_power_status);
`default_nettype wire

/* dv/cfg_host_model.sv */
/* System processor model on the configuration port: byte cycles, chars.
   Assumes it shares clk_sys with the register block. */
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model
	import hub_cfg_pkg::*;
(
	input  wire logic     clk_sys,
	output var  cfg_req_s cfg_req,
	input  wire cfg_rsp_s cfg_rsp
);
	initial cfg_req = '0;
	// Idle address and data are inverted so a stale value never looks valid
	task automatic put(input logic [7:0] a, d, input logic r);
		@(posedge clk_sys);
		cfg_req <= '{!r, r, a, d};
		@(posedge clk_sys);
		cfg_req <= '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic put_char(input logic [7:0] a, input logic [15:0] c);
		put(a, c[7:0], 1'b0);
		put(a + 8'h01, c[15:8], 1'b0);
	endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
/* Self-checking bench for the string and port power register block.
   Config cycles come from the host model; the bench drives the rest. */
`timescale 1ns/1ps
`default_nettype none
module tb
	import hub_cfg_pkg::*;
;
	logic       clk_sys = 1'b0;
	logic       resetn = 1'b0;
	cfg_req_s   req;
	cfg_rsp_s   rsp;
	desc_req_s  dq = '0;
	desc_rsp_s  ds;
	logic [2:0] hp = 3'h0, oc = 3'h0, rc = 3'h0, bc, ps;
	logic [7:0] d, v;
	logic [8:0] r;
	logic [15:0] c;
	int         err_total = 0, check_count = 0;
	always #2 clk_sys = ~clk_sys;
	cfg_host_model m (.clk_sys, .cfg_req(req), .cfg_rsp(rsp));
	hub_string_and_port_power_regs DUT (.clk_sys, .resetn, .cfg_req(req), .cfg_rsp(rsp),
		.desc_req(dq), .desc_rsp(ds), .host_port_power_req(hp), .overcurrent_flag_bits(oc),
		.overcurrent_reg_control(rc), .battery_charge_enable(bc), .port_power_status(ps));
	task automatic stop_test;
		if (err_total == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic rd(input logic [7:0] a, e);
		m.put(a, 8'h00, 1'b1);
		#1 chk(rsp.valid ? rsp.rdata : ~e, e);
	endtask
	task automatic dr(input logic s, input logic [5:0] i, input logic [7:0] e);
		@(posedge clk_sys);
		dq <= '{1'b1, string_sel_e'(s), i};
		@(posedge clk_sys);
		dq <= '{1'b0, string_sel_e'(~s), ~i};
		#1 chk(ds.valid ? ds.data : ~e, e);
	endtask
	function automatic logic [2:0] pexp(input logic [2:0] h, o, k, b);
		return h & ~(o & (b | k));
	endfunction
	initial begin
		#100000;
		err_total++;
		stop_test();
	end
	initial begin
		void'($urandom(62568));
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(8'hD0, 8'h00);
		rd(8'h54, 8'h00);
		// First and last character of each string, then one byte past the end
		for (int s = 0; s < 2; s++) begin
			for (int k = 0; k < 62; k += 60) begin
				c = 16'($urandom);
				v = (s ? 8'h92 : 8'h54) + 8'(k);
				m.put_char(v, c);
				dr(s[0], 6'(k), c[7:0]);
				dr(s[0], 6'(k + 1), c[15:8]);
				rd(v + 8'h01, c[15:8]);
			end
			dr(s[0], 6'h3E, 8'h00);
		end
		m.put(8'hD0, 8'hFF, 1'b0);
		rd(8'hD0, 8'h0E);
		m.put(8'hE5, 8'hFF, 1'b0);
		rd(8'hE5, 8'h00);
		rd(8'hF0, 8'h00);
		repeat (40) begin
			d = 8'($urandom);
			r = 9'($urandom);
			m.put(8'hD0, d, 1'b0);
			@(posedge clk_sys);
			{hp, oc, rc} <= r;
			chk({5'h00, bc}, {5'h00, d[3:1]});
			rd(8'hE5, {4'h0, pexp(r[8:6], r[5:3], r[2:0], d[3:1]), 1'b0});
			chk({5'h00, ps}, {5'h00, pexp(r[8:6], r[5:3], r[2:0], d[3:1])});
		end
		stop_test();
	end
endmodule
`default_nettype wire
